// file: verilog/dfm_pkg.sv
// Constants, register map, descriptor layout and state types for the
// dual-FIFO transmit-descriptor MAC.
// Assumes a 100 MHz system clock and a 16-bit shared descriptor memory.
package dfm_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses on APB)
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_TXRING  = 8'h04;
  localparam logic [7:0] REG_RXBUF   = 8'h08;
  localparam logic [7:0] REG_DEMAND  = 8'h0C;
  localparam logic [7:0] REG_STATUS  = 8'h10;
  localparam logic [7:0] REG_RXPTR   = 8'h14;
  localparam logic [7:0] REG_TXPKTS  = 8'h18;

  // CTRL (mode) fields
  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_DISABLE_TX_CRC_FLAG_BIT  = 1;
  localparam int CTRL_MODIFIED_BACKOFF_ENABLE_BIT  = 7;
  // STATUS fields
  localparam int STAT_LOADED_BIT = 0;
  localparam int STAT_WIRE_BIT   = 1;
  localparam int STAT_POLL_BIT   = 2;
  localparam int STAT_OVF_BIT    = 3;

  // ----------------------------------------------------------------------
  // Transmit descriptor layout (four 16-bit words)
  // ----------------------------------------------------------------------
  localparam logic [23:0] DESC_W0_OFS  = 24'h000000;
  localparam logic [23:0] DESC_W1_OFS  = 24'h000002;
  localparam logic [23:0] DESC_W2_OFS  = 24'h000004;
  localparam logic [23:0] DESC_SIZE    = 24'h000008;
  localparam int          W1_OWN_BIT   = 15;
  localparam int          W1_APPEND_BIT = 13;
  localparam int          W1_STP_BIT   = 9;
  localparam int          W1_ENP_BIT   = 8;

  // ----------------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------------
  localparam int TX_FIFO_BYTES = 48;
  localparam int RX_FIFO_BYTES = 64;
  localparam int TX_START_LEVEL = 32;
  localparam int RING_BITS     = 3;
  localparam int CLK_MHZ       = 100;
  localparam int IFS_NS        = 9600;
  localparam int IFS_CYC       = (IFS_NS * CLK_MHZ + 999) / 1000;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;

  typedef enum logic [2:0] {
    D_IDLE, D_RXW, D_TXW1, D_TXW0, D_TXW2, D_TXDAT, D_TXST
  } dfm_dma_type;

  typedef enum logic [1:0] {W_IDLE, W_IFS, W_DATA, W_FCS} dfm_wire_type;

  // Circular pointer step for FIFOs whose depth is not a power of two
  function automatic logic [6:0] ptr_step(input logic [6:0] p,
                                          input int         depth);
    ptr_step = (p == 7'(depth - 1)) ? 7'h00 : p + 7'h01;
  endfunction : ptr_step

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == REG_CTRL) || (a == REG_TXRING) || (a == REG_RXBUF) ||
              (a == REG_DEMAND) || (a == REG_STATUS) ||
              (a == REG_RXPTR) || (a == REG_TXPKTS);
  endfunction : reg_hit

endpackage : dfm_pkg

// file: verilog/dfm_crc32.sv
// Byte-wide reflected CRC-32 accumulator for the transmit frame.
// Assumes clr_i and en_i are never needed in the same cycle.
`timescale 1ns/1ns
module dfm_crc32
  import dfm_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        clr_i,
  input  wire logic        en_i,
  input  wire logic [7:0]  data_i,
  output logic      [31:0] crc_o
);

  typedef struct packed {
    logic [31:0] crc;
  } dfm_crc_state_type;

  dfm_crc_state_type s;
  dfm_crc_state_type next_s;

  always_comb begin
    logic [31:0] c;
    c = s.crc;
    next_s = s;
    if (clr_i) begin
      next_s.crc = CRC_INIT;
    end else if (en_i) begin
      c = c ^ {24'h000000, data_i};
      for (int i = 0; i < 8; i++) begin
        c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      next_s.crc = c;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s.crc <= CRC_INIT;
    end else begin
      s <= next_s;
    end
  end

  assign crc_o = s.crc;

endmodule : dfm_crc32

// file: verilog/dfm_mac.sv
// Transmit/receive scheduling core: APB registers, interleaved descriptor
// DMA over a 16-bit memory port, separate TX/RX FIFOs, byte-wide link.
// Assumes all inputs are synchronous to clk_i and memory holds requests.
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ns

// Contract
// - Separate TX FIFO 48 bytes, RX 64
// - Poll TX descriptor early in each reception
// - Interleave TX fill with RX drain DMA
// - Preloaded frame sends right after receive ends
// - Disable flag clear: always append FCS
// - Disable flag set: append only if bit set
// - Append bit is word-1 bit 13
// - Append bit used only in start descriptors
// - Status write keeps bit 13 as read
// - Mode bit 7 selects modified backoff
// - Modified backoff pauses IFS during carrier
// - Byte count two's complement, expires at zero
// - Full 16-bit word-2 byte count
// - Zero count releases descriptor without data DMA
// - Only all-zero means empty; 4096 works
module dfm_mac
  import dfm_pkg::*;
#(
  parameter int TX_DEPTH = TX_FIFO_BYTES,
  parameter int RX_DEPTH = RX_FIFO_BYTES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic      [23:0] mem_addr_o,
  output logic      [15:0] mem_wdata_o,
  input  wire logic [15:0] mem_rdata_i,
  input  wire logic        mem_ack_i,
  output logic             tx_en_o,
  output logic             tx_valid_o,
  output logic      [7:0]  tx_byte_o,
  input  wire logic        tx_ready_i,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_byte_i,
  input  wire logic        rx_end_i,
  input  wire logic        rx_carrier_i
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                        run, disable_tx_crc_flag, modified_backoff_enable, ovf;
    logic [23:0]                 ring_base, rxbuf_base, rx_ptr;
    logic [31:0]                 prdata;
    logic                        pready, pslverr;
    dfm_dma_type                 dma, tx_step;
    logic                        mem_req, mem_we;
    logic [23:0]                 mem_addr;
    logic [15:0]                 mem_wdata;
    logic [23:0]                 desc_addr, buf_addr;
    logic [RING_BITS-1:0]        desc_idx;
    logic [15:0]                 w1, buffer_byte_count;
    logic                        poll_pend, last_rx, load_done, crc_on;
    logic [TX_DEPTH-1:0][7:0]    txf;
    logic [6:0]                  tx_wp, tx_rp, tx_cnt;
    logic [RX_DEPTH-1:0][7:0]    rxf;
    logic [6:0]                  rx_wp, rx_rp, rx_cnt;
    logic [1:0]                  rx_take;
    logic                        rx_busy, rx_flush;
    dfm_wire_type                wire_st;
    logic [15:0]                 ifs_cnt;
    logic [1:0]                  fcs_idx;
    logic                        tx_en, tx_valid;
    logic [7:0]                  tx_byte;
    logic [15:0]                 tx_pkts;
  } dfm_state_type;

  dfm_state_type s;
  dfm_state_type next_s;

  logic        crc_clr;
  logic        crc_en;
  logic [7:0]  crc_byte;
  logic [31:0] crc_q;

  dfm_crc32 u_crc (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .clr_i   (crc_clr),
    .en_i    (crc_en),
    .data_i  (crc_byte),
    .crc_o   (crc_q)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic        wr, rx_need, tx_need, tpop, rpush;
    logic [1:0]  tpush, rpop;
    logic [7:0]  tb0, tb1;
    logic [15:0] nb;
    logic [31:0] fcs;
    wr = 1'b0;
    rx_need = 1'b0;
    tx_need = 1'b0;
    tpop = 1'b0;
    rpush = 1'b0;
    tpush = 2'd0;
    rpop = 2'd0;
    tb0 = 8'h00;
    tb1 = 8'h00;
    nb = 16'h0000;
    fcs = ~crc_q;
    crc_clr = 1'b0;
    crc_en = 1'b0;
    crc_byte = 8'h00;
    next_s = s;

    // ---------------------------------------------------------------
    // APB slave: setup cycle latches the answer, access ends at once
    // ---------------------------------------------------------------
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    if (psel_i && !penable_i) begin
      next_s.pready = 1'b1;
      next_s.pslverr = !reg_hit(paddr_i);
      case (paddr_i)
        REG_CTRL: next_s.prdata = {24'h000000, s.modified_backoff_enable, 5'h00,
                                   s.disable_tx_crc_flag, s.run};
        REG_TXRING: next_s.prdata = {8'h00, s.ring_base};
        REG_RXBUF: next_s.prdata = {8'h00, s.rxbuf_base};
        REG_STATUS: next_s.prdata = {28'h0000000, s.ovf, s.poll_pend,
                                     s.wire_st != W_IDLE, s.load_done};
        REG_RXPTR: next_s.prdata = {8'h00, s.rx_ptr};
        REG_TXPKTS: next_s.prdata = {16'h0000, s.tx_pkts};
        default: next_s.prdata = 32'h00000000;
      endcase
    end
    wr = psel_i && penable_i && pwrite_i && s.pready && !s.pslverr;
    if (wr) begin
      case (paddr_i)
        REG_CTRL: begin
          next_s.run = pwdata_i[CTRL_RUN_BIT];
          // Mode bits are frozen while running: taken at initialization
          if (!s.run) begin
            next_s.disable_tx_crc_flag = pwdata_i[CTRL_DISABLE_TX_CRC_FLAG_BIT];
            next_s.modified_backoff_enable = pwdata_i[CTRL_MODIFIED_BACKOFF_ENABLE_BIT];
          end
          if (!s.run && pwdata_i[CTRL_RUN_BIT]) begin
            next_s.desc_addr = s.ring_base;
            next_s.desc_idx = '0;
            next_s.rx_ptr = s.rxbuf_base;
            next_s.poll_pend = 1'b1;
          end
        end
        REG_TXRING: next_s.ring_base = pwdata_i[23:0];
        REG_RXBUF: next_s.rxbuf_base = pwdata_i[23:0];
        REG_DEMAND: next_s.poll_pend = s.poll_pend | pwdata_i[0];
        REG_STATUS: begin
          if (pwdata_i[STAT_OVF_BIT]) begin
            next_s.ovf = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // ---------------------------------------------------------------
    // Receive side: bytes into the RX FIFO
    // ---------------------------------------------------------------
    if (rx_valid_i) begin
      if (!s.rx_busy) begin
        next_s.rx_busy = 1'b1;
        next_s.poll_pend = 1'b1;
      end
      if (s.rx_cnt != 7'(RX_DEPTH)) begin
        rpush = 1'b1;
      end else begin
        next_s.ovf = 1'b1;
      end
    end
    if (rx_end_i) begin
      next_s.rx_busy = 1'b0;
      next_s.rx_flush = 1'b1;
    end

    // ---------------------------------------------------------------
    // DMA: one memory word at a time, alternating RX and TX work
    // ---------------------------------------------------------------
    if (s.tx_step == D_IDLE && s.poll_pend && !s.load_done && s.run) begin
      next_s.tx_step = D_TXW1;
      next_s.poll_pend = rx_valid_i && !s.rx_busy;
    end
    rx_need = (s.rx_cnt >= 7'd2) || (s.rx_flush && s.rx_cnt != 7'd0);
    tx_need = (s.tx_step != D_IDLE) && ((s.tx_step != D_TXDAT) ||
              (7'(TX_DEPTH) - s.tx_cnt >= 7'd2));
    if (s.dma == D_IDLE && s.run) begin
      if (rx_need && (!tx_need || !s.last_rx)) begin
        next_s.dma = D_RXW;
        next_s.mem_req = 1'b1;
        next_s.mem_we = 1'b1;
        next_s.mem_addr = s.rx_ptr;
        next_s.last_rx = 1'b1;
        next_s.rx_take = (s.rx_cnt >= 7'd2) ? 2'd2 : 2'd1;
        next_s.mem_wdata = {(s.rx_cnt >= 7'd2) ?
                            s.rxf[ptr_step(s.rx_rp, RX_DEPTH)] : 8'h00,
                            s.rxf[s.rx_rp]};
      end else if (tx_need) begin
        next_s.dma = s.tx_step;
        next_s.mem_req = 1'b1;
        next_s.mem_we = (s.tx_step == D_TXST);
        next_s.last_rx = 1'b0;
        case (s.tx_step)
          D_TXW0: next_s.mem_addr = s.desc_addr + DESC_W0_OFS;
          D_TXW2: next_s.mem_addr = s.desc_addr + DESC_W2_OFS;
          D_TXDAT: next_s.mem_addr = s.buf_addr;
          default: next_s.mem_addr = s.desc_addr + DESC_W1_OFS;
        endcase
        // Ownership handed back; every other bit, bit 13 included, as read
        next_s.mem_wdata = s.w1 & ~(16'h0001 << W1_OWN_BIT);
      end
    end
    if (s.mem_req && mem_ack_i) begin
      next_s.mem_req = 1'b0;
      next_s.mem_we = 1'b0;
      next_s.dma = D_IDLE;
      case (s.dma)
        D_RXW: begin
          rpop = s.rx_take;
          next_s.rx_ptr = s.rx_ptr + 24'h000002;
          if (s.rx_cnt == 7'(s.rx_take)) begin
            next_s.rx_flush = 1'b0;
          end
        end
        D_TXW1: begin
          next_s.w1 = mem_rdata_i;
          if (!mem_rdata_i[W1_OWN_BIT]) begin
            next_s.tx_step = D_IDLE;
          end else begin
            next_s.tx_step = D_TXW0;
            if (mem_rdata_i[W1_STP_BIT]) begin
              next_s.crc_on = !s.disable_tx_crc_flag || mem_rdata_i[W1_APPEND_BIT];
            end
          end
        end
        D_TXW0: begin
          next_s.buf_addr = {s.w1[7:0], mem_rdata_i};
          next_s.tx_step = D_TXW2;
        end
        D_TXW2: begin
          next_s.buffer_byte_count = mem_rdata_i;
          // Empty buffer: straight to the status write, no data fetch
          next_s.tx_step = (mem_rdata_i == 16'h0000) ?
                           D_TXST : D_TXDAT;
        end
        D_TXDAT: begin
          tb0 = mem_rdata_i[7:0];
          tpush = 2'd1;
          nb = s.buffer_byte_count + 16'h0001;
          if (nb != 16'h0000) begin
            tb1 = mem_rdata_i[15:8];
            tpush = 2'd2;
            nb = s.buffer_byte_count + 16'h0002;
          end
          next_s.buffer_byte_count = nb;
          next_s.buf_addr = s.buf_addr + 24'h000002;
          if (nb == 16'h0000) begin
            next_s.tx_step = D_TXST;
          end
        end
        D_TXST: begin
          next_s.tx_step = D_IDLE;
          next_s.poll_pend = 1'b1;
          next_s.load_done = s.w1[W1_ENP_BIT];
          if (s.desc_idx == '1) begin
            next_s.desc_addr = s.ring_base;
            next_s.desc_idx = '0;
          end else begin
            next_s.desc_addr = s.desc_addr + DESC_SIZE;
            next_s.desc_idx = s.desc_idx + 1'b1;
          end
        end
        default: ;
      endcase
    end

    // ---------------------------------------------------------------
    // Link side: deferral, data, then the frame check sequence
    // ---------------------------------------------------------------
    next_s.tx_valid = 1'b0;
    case (s.wire_st)
      W_IDLE: begin
        next_s.tx_en = 1'b0;
        if (s.tx_cnt != 7'd0 && (s.load_done ||
            s.tx_cnt >= 7'(TX_START_LEVEL))) begin
          next_s.wire_st = W_IFS;
          next_s.ifs_cnt = 16'h0000;
        end else if (s.load_done && s.tx_cnt == 7'd0 &&
                     s.dma != D_TXST) begin
          next_s.load_done = 1'b0;
        end
      end
      W_IFS: begin
        // A frame already in the FIFO leaves only after the IFS_CYC gap has been counted out with carrier low
        if (rx_carrier_i) begin
          if (!s.modified_backoff_enable) begin
            next_s.ifs_cnt = 16'h0000;
          end
        end else if (s.ifs_cnt == 16'(IFS_CYC - 1)) begin
          next_s.wire_st = W_DATA;
          next_s.tx_en = 1'b1;
          crc_clr = 1'b1;
        end else begin
          next_s.ifs_cnt = s.ifs_cnt + 16'h0001;
        end
      end
      W_DATA: begin
        // FIFO running dry mid-frame stalls the link rather than aborting
        if (tx_ready_i && s.tx_cnt != 7'd0) begin
          tpop = 1'b1;
          next_s.tx_valid = 1'b1;
          next_s.tx_byte = s.txf[s.tx_rp];
          crc_en = 1'b1;
          crc_byte = s.txf[s.tx_rp];
        end else if (s.tx_cnt == 7'd0 && s.load_done) begin
          if (s.crc_on) begin
            next_s.wire_st = W_FCS;
            next_s.fcs_idx = 2'd0;
          end else begin
            next_s.wire_st = W_IDLE;
            next_s.load_done = 1'b0;
            next_s.tx_pkts = s.tx_pkts + 16'h0001;
          end
        end
      end
      W_FCS: begin
        if (tx_ready_i) begin
          next_s.tx_valid = 1'b1;
          next_s.tx_byte = fcs[8 * s.fcs_idx +: 8];
          next_s.fcs_idx = s.fcs_idx + 2'd1;
          if (s.fcs_idx == 2'd3) begin
            next_s.wire_st = W_IDLE;
            next_s.load_done = 1'b0;
            next_s.tx_pkts = s.tx_pkts + 16'h0001;
          end
        end
      end
      default: next_s.wire_st = W_IDLE;
    endcase

    // ---------------------------------------------------------------
    // FIFO bookkeeping
    // ---------------------------------------------------------------
    if (tpush != 2'd0) begin
      next_s.txf[s.tx_wp] = tb0;
      next_s.tx_wp = ptr_step(s.tx_wp, TX_DEPTH);
      if (tpush == 2'd2) begin
        next_s.txf[ptr_step(s.tx_wp, TX_DEPTH)] = tb1;
        next_s.tx_wp = ptr_step(ptr_step(s.tx_wp, TX_DEPTH), TX_DEPTH);
      end
    end
    if (tpop) begin
      next_s.tx_rp = ptr_step(s.tx_rp, TX_DEPTH);
    end
    next_s.tx_cnt = s.tx_cnt + 7'(tpush) - 7'(tpop);
    if (rpush) begin
      next_s.rxf[s.rx_wp] = rx_byte_i;
      next_s.rx_wp = ptr_step(s.rx_wp, RX_DEPTH);
    end
    if (rpop != 2'd0) begin
      next_s.rx_rp = (rpop == 2'd2) ?
                     ptr_step(ptr_step(s.rx_rp, RX_DEPTH), RX_DEPTH) :
                     ptr_step(s.rx_rp, RX_DEPTH);
    end
    next_s.rx_cnt = s.rx_cnt + 7'(rpush) - 7'(rpop);
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign prdata_o    = s.prdata;
  assign pready_o    = s.pready;
  assign pslverr_o   = s.pslverr;
  assign mem_req_o   = s.mem_req;
  assign mem_we_o    = s.mem_we;
  assign mem_addr_o  = s.mem_addr;
  assign mem_wdata_o = s.mem_wdata;
  assign tx_en_o     = s.tx_en;
  assign tx_valid_o  = s.tx_valid;
  assign tx_byte_o   = s.tx_byte;

endmodule : dfm_mac

// file: verif/dfm_mem_model.sv
// Shared descriptor and buffer memory behind the controller's DMA port.
// Assumes the controller holds each request until it is acknowledged.
`timescale 1ns/1ns
module dfm_mem_model (
  input  wire logic        clk_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [23:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic [3:0]  lat_i,
  output logic      [15:0] rdata_o,
  output logic             ack_o
);
  logic [15:0] mem [0:8191];
  logic [3:0]  cnt = 4'h0;

  initial begin
    ack_o = 1'b0;
    rdata_o = 16'h0000;
    foreach (mem[i]) mem[i] = 16'h0000;
  end

  // Read data is only good in the ack cycle; it toggles otherwise so a
  // late sample cannot pass by luck
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    cnt <= 4'h0;
    if (req_i && !ack_o) begin
      cnt <= cnt + 4'h1;
      if (cnt >= lat_i) begin
        ack_o <= 1'b1;
        if (we_i) mem[addr_i[13:1]] <= wdata_i;
        else rdata_o <= mem[addr_i[13:1]];
      end
    end
  end
endmodule : dfm_mem_model

// file: verif/dfm_mac_checker.sv
// Port-level assertions for the MAC core.
// Assumes it is bound into dfm_mac and sees only its ports.
`timescale 1ns/1ns
module dfm_mac_checker #(
  parameter int TX_DEPTH = 48,
  parameter int RX_DEPTH = 64
) (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        mem_req_o,
  input wire logic        mem_we_o,
  input wire logic [23:0] mem_addr_o,
  input wire logic [15:0] mem_wdata_o,
  input wire logic        mem_ack_i,
  input wire logic        tx_en_o,
  input wire logic        tx_valid_o,
  input wire logic        tx_ready_i,
  input wire logic        rx_carrier_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  setup_ready_a: assert property (psel_i && !penable_i |=> pready_o)
    else $error("pready missing after setup");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  unmapped_err_a: assert property (psel_i && penable_i &&
    (paddr_i > 8'h18 || paddr_i[1:0] != 2'b00) |-> pslverr_o &&
    prdata_o == 32'h0) else $error("unmapped access not refused");
  err_ready_a: assert property (pslverr_o |-> pready_o && penable_i)
    else $error("pslverr outside access");
  mem_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o &&
    $stable(mem_addr_o) && $stable(mem_we_o) && $stable(mem_wdata_o))
    else $error("memory request changed");
  req_drop_a: assert property (mem_req_o && mem_ack_i |=> !mem_req_o)
    else $error("memory request not dropped");
  byte_answer_a: assert property (tx_valid_o |-> $past(tx_ready_i) &&
    tx_en_o) else $error("byte without request");
  carrier_hold_a: assert property (!tx_en_o && rx_carrier_i |=> !tx_en_o)
    else $error("transmit started under carrier");
endmodule : dfm_mac_checker

bind dfm_mac dfm_mac_checker #(.TX_DEPTH(TX_DEPTH), .RX_DEPTH(RX_DEPTH))
  u_chk (.clk_i, .rst_n_i, .psel_i, .penable_i, .paddr_i, .prdata_o,
  .pready_o, .pslverr_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o,
  .mem_ack_i, .tx_en_o, .tx_valid_o, .tx_ready_i, .rx_carrier_i);

// file: verif/tb_top.sv
// Self-checking bench for the MAC core: APB master, memory model, link.
// Assumes dfm_pkg, dfm_mac and the memory model are compiled first.
`timescale 1ns/1ns
module tb_top;
  import dfm_pkg::*;
  logic clk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic tx_ready_i = 0, rx_valid_i = 0, rx_end_i = 0, rx_carrier_i = 0;
  logic [7:0] paddr_i = 8'h00, rx_byte_i = 8'h00, tx_byte_o;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd, sent = 32'h0;
  logic pready_o, pslverr_o, mem_req_o, mem_we_o, mem_ack_i, err, seen;
  logic tx_en_o, tx_valid_o;
  logic [23:0] mem_addr_o;
  logic [15:0] mem_wdata_o, mem_rdata_i;
  logic [3:0] lat = 4'h0;
  logic [7:0] txq[$];
  int failures = 0, checked = 0, bufrd = 0;

  always #5 clk_i = ~clk_i;

  dfm_mac DUT (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .mem_req_o, .mem_we_o,
    .mem_addr_o, .mem_wdata_o, .mem_rdata_i, .mem_ack_i, .tx_en_o,
    .tx_valid_o, .tx_byte_o, .tx_ready_i, .rx_valid_i, .rx_byte_i,
    .rx_end_i, .rx_carrier_i);
  dfm_mem_model MEM (.clk_i, .req_i(mem_req_o), .we_i(mem_we_o),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .lat_i(lat),
    .rdata_o(mem_rdata_i), .ack_o(mem_ack_i));

  // Link adapter asks for a byte every other cycle while a frame is up
  always @(posedge clk_i) begin
    tx_ready_i <= tx_en_o && !tx_ready_i;
    if (tx_valid_o) txq.push_back(tx_byte_o);
    if (tx_en_o) seen <= 1'b1;
    if (mem_req_o && mem_ack_i && !mem_we_o && mem_addr_o[23:8] != 16'h0)
      bufrd++;
  end

  function automatic logic [7:0] bt(input int i);
    return 8'(i * 7 + 3);
  endfunction : bt

  task automatic test_done;
    if (failures == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done

  task automatic cmp(input logic [31:0] got, exp, input string what);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp

  // 0: pready, 1: frame up, 2: frame over, 3: descriptor released
  task automatic wt(input int sel, input int lim);
    int n;
    n = 0;
    while (!(sel == 0 ? pready_o === 1'b1 : sel == 1 ? tx_en_o === 1'b1 :
             sel == 2 ? tx_en_o === 1'b0 : MEM.mem[1][15] === 1'b0)) begin
      @(posedge clk_i);
      n++;
      if (n > lim) begin
        failures++;
        $display("ERROR %0t timeout waiting %0d", $time, sel);
        test_done();
      end
    end
  endtask : wt

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    wt(0, 50);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask : apb

  task automatic t_regs;
    apb(1'b1, REG_RXBUF, 32'h3000);
    apb(1'b0, REG_RXBUF, 32'h0);
    cmp(rd, 32'h3000, "rx base");
    apb(1'b1, 8'h1C, 32'hFFFF);
    apb(1'b0, 8'h1C, 32'h0);
    cmp({31'h0, err}, 32'h1, "refusal");
    cmp(rd, 32'h0, "unmapped data");
    apb(1'b1, REG_TXRING, 32'h0);
  endtask : t_regs

  task automatic t_frame(input logic disable_tx_crc_flag, add, modified_backoff_enable, rx, input int len);
    logic [31:0] c;
    int k;
    logic fcs;
    fcs = !disable_tx_crc_flag || add;
    txq.delete();
    MEM.mem[1] = {!rx, 1'b0, add, 5'b00011, 8'h00};
    MEM.mem[0] = 16'h0100;
    MEM.mem[2] = 16'(-len);
    for (k = 0; k < len; k++) MEM.mem[128 + k / 2][8 * (k % 2) +: 8] = bt(k);
    apb(1'b1, REG_CTRL, 32'h0);
    apb(1'b1, REG_CTRL, {24'h0, modified_backoff_enable, 5'h0, disable_tx_crc_flag, 1'b1});
    if (rx) begin
      // Owned only after the run poll, so only a poll during receive finds it
      repeat (40) @(posedge clk_i);
      MEM.mem[1][15] = 1'b1;
      rx_carrier_i <= 1'b1;
      for (k = 0; k < 60; k++) begin
        repeat (3) @(posedge clk_i);
        rx_valid_i <= 1'b1;
        rx_byte_i <= bt(k + 9);
        @(posedge clk_i);
        rx_valid_i <= 1'b0;
      end
      rx_end_i <= 1'b1;
      rx_carrier_i <= 1'b0;
      @(posedge clk_i);
      rx_end_i <= 1'b0;
      wt(1, 1000);
    end else begin
      // Carrier blip mid-gap: a paused count resumes, a standard one restarts
      repeat (500) @(posedge clk_i);
      rx_carrier_i <= 1'b1;
      @(posedge clk_i);
      rx_carrier_i <= 1'b0;
      if (modified_backoff_enable) begin
        wt(1, 700);
      end else begin
        repeat (900) @(posedge clk_i);
        cmp({31'h0, tx_en_o}, 32'h0, "gap restart");
      end
    end
    wt(1, 3000);
    wt(2, 30000);
    wt(3, 2000);
    sent++;
    cmp(32'(txq.size()), 32'(len + (fcs ? 4 : 0)), "length");
    c = CRC_INIT;
    for (k = 0; k < len; k++) begin
      cmp({24'h0, txq[k]}, {24'h0, bt(k)}, "data");
      c = c ^ {24'h0, bt(k)};
      repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    for (k = 0; k < 4 && fcs; k++)
      cmp({24'h0, txq[len + k]}, {24'h0, 8'(~c >> (8 * k))}, "fcs");
    cmp({16'h0, MEM.mem[1]}, {18'h0, add, 13'h0300}, "status");
    for (k = 0; k < 30 && rx; k++)
      cmp({16'h0, MEM.mem[6144 + k]}, {16'h0, bt(2 * k + 10), bt(2 * k + 9)},
          "rx drain");
    apb(1'b0, REG_TXPKTS, 32'h0);
    cmp(rd, sent, "sent count");
  endtask : t_frame

  task automatic t_zero;
    int b;
    MEM.mem[1] = 16'h8300;
    MEM.mem[2] = 16'h0000;
    b = bufrd;
    seen = 1'b0;
    apb(1'b1, REG_CTRL, 32'h0);
    apb(1'b1, REG_CTRL, 32'h1);
    wt(3, 2000);
    // Longer than the interframe gap, so a wrong start would show
    repeat (1200) @(posedge clk_i);
    cmp({16'h0, MEM.mem[1]}, 32'h0300, "released");
    cmp(32'(bufrd - b), 32'h0, "buffer reads");
    cmp({31'h0, seen}, 32'h0, "wire used");
    apb(1'b0, REG_TXPKTS, 32'h0);
    cmp(rd, sent, "sent count");
  endtask : t_zero

  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    t_regs();
    t_frame(1'b0, 1'b0, 1'b0, 1'b0, 5);
    lat <= 4'h3;
    t_frame(1'b1, 1'b0, 1'b1, 1'b0, 6);
    t_frame(1'b1, 1'b1, 1'b1, 1'b1, 40);
    lat <= 4'h0;
    t_zero();
    t_frame(1'b0, 1'b1, 1'b0, 1'b0, 4096);
    test_done();
  end
endmodule : tb_top
